// ===== hdl/fpsf_flag_logic.v
// Status flag generation for a single-cycle 32-bit floating-point unit.
// Assumes the datapath reports result conditions on the same clock; the
// pass-through selects come from pins and are synchronised here.
`timescale 1ns/1ps
`include "fpsf_defines.vh"

module fpsf_flag_logic (
    // Clock and reset
    input  wire       CORE_CLK_IN,
    input  wire       RST_B_IN,
    // Operation select
    input  wire [2:0] OP_SEL_IN,
    input  wire       IEEE_MODE_IN,
    // Result conditions from the datapath
    input  wire       INVALID_CASE_IN,
    input  wire       FINITE_OPERANDS_IN,
    input  wire       RESULT_OVF_IN,
    input  wire       RESULT_TINY_IN,
    input  wire       RESULT_INEXACT_IN,
    input  wire       RESULT_ZERO_IN,
    input  wire       RESULT_NAN_IN,
    input  wire       INPUT_NAN_IN,
    input  wire       INT_RANGE_ERR_IN,
    // Register controls
    input  wire       INPUT_PASS_THROUGH_SEL_IN,
    input  wire       OUTPUT_PASS_THROUGH_SEL_IN,
    input  wire       INPUT_REG_EN_IN,
    input  wire       OUTPUT_REG_EN_IN,
    // Flags
    output wire       INVALID_OP_FLAG_OUT,
    output wire       RESULT_TOO_LARGE_FLAG_OUT,
    output wire       RESULT_TOO_SMALL_FLAG_OUT,
    output wire       ROUNDING_OCCURRED_FLAG_OUT,
    output wire       ZERO_RESULT_FLAG_OUT,
    output wire       NAN_FLAG_OUT
);

    // ------------------------------------------------------------------
    // Flag encoding
    // ------------------------------------------------------------------
    // Returns {nan, zer, ine, unf, ovf, inv}; earlier branches win.
    function [`FPSF_FLAG_W-1:0] flags_for;
        input [2:0]            op;
        input                  ieee;
        input [`FPSF_CND_W-1:0] c;
        reg                    arith4;
        reg                    arith3;
        reg                    nan_op;
        reg [`FPSF_FLAG_W-1:0] f;
        begin
            arith4 = (op <= `FPSF_OP_TWO_MINUS_S);
            arith3 = (op <= `FPSF_OP_R_TIMES_S);
            nan_op = arith4 || (op == `FPSF_OP_FLOAT_TO_INT);
            f      = `FPSF_FLAGS_RST;
            if (op == `FPSF_OP_IEEE_TO_ALT) begin
                if (c[`FPSF_CND_IN_NAN]) begin
                    f[`FPSF_FLAG_INV] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (c[`FPSF_CND_OVF]) begin
                    f[`FPSF_FLAG_OVF] = 1'b1;
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (c[`FPSF_CND_ZERO]) begin
                    f[`FPSF_FLAG_ZER] = 1'b1;
                    f[`FPSF_FLAG_UNF] = c[`FPSF_CND_TINY];
                    f[`FPSF_FLAG_INE] = c[`FPSF_CND_INEXACT];
                end else begin
                    f[`FPSF_FLAG_INE] = c[`FPSF_CND_INEXACT];
                end
            end else if (op == `FPSF_OP_ALT_TO_IEEE) begin
                if (c[`FPSF_CND_IN_NAN]) begin
                    f[`FPSF_FLAG_INV] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (c[`FPSF_CND_TINY]) begin
                    f[`FPSF_FLAG_UNF] = 1'b1;
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_ZER] = 1'b1;
                end else if (c[`FPSF_CND_ZERO]) begin
                    f[`FPSF_FLAG_ZER] = 1'b1;
                    f[`FPSF_FLAG_INE] = c[`FPSF_CND_INEXACT];
                end else begin
                    f[`FPSF_FLAG_INE] = c[`FPSF_CND_INEXACT];
                end
            end else if (ieee) begin
                if (c[`FPSF_CND_INVALID]) begin
                    f[`FPSF_FLAG_INV] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (arith4 && c[`FPSF_CND_FINITE] && c[`FPSF_CND_OVF]) begin
                    f[`FPSF_FLAG_OVF] = 1'b1;
                    f[`FPSF_FLAG_INE] = 1'b1;
                end else if (arith3 && c[`FPSF_CND_TINY]) begin
                    f[`FPSF_FLAG_UNF] = 1'b1;
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_ZER] = 1'b1;
                end else if (nan_op && c[`FPSF_CND_RES_NAN]) begin
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (c[`FPSF_CND_ZERO]) begin
                    f[`FPSF_FLAG_ZER] = 1'b1;
                    f[`FPSF_FLAG_UNF] = c[`FPSF_CND_TINY];
                    f[`FPSF_FLAG_INE] = c[`FPSF_CND_INEXACT];
                end else if (c[`FPSF_CND_INEXACT]) begin
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_OVF] = c[`FPSF_CND_OVF];
                    f[`FPSF_FLAG_UNF] = c[`FPSF_CND_TINY];
                end
            end else begin
                if ((op == `FPSF_OP_FLOAT_TO_INT) && c[`FPSF_CND_IN_NAN]) begin
                    f[`FPSF_FLAG_INV] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if ((op == `FPSF_OP_FLOAT_TO_INT) && c[`FPSF_CND_INT_RANGE]) begin
                    f[`FPSF_FLAG_INV] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (arith4 && c[`FPSF_CND_OVF]) begin
                    f[`FPSF_FLAG_OVF] = 1'b1;
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_NAN] = 1'b1;
                end else if (arith3 && c[`FPSF_CND_TINY]) begin
                    f[`FPSF_FLAG_UNF] = 1'b1;
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_ZER] = 1'b1;
                end else if (nan_op && c[`FPSF_CND_RES_NAN]) begin
                    // Invalid and overflow are reported as the datapath saw them
                    f[`FPSF_FLAG_NAN] = 1'b1;
                    f[`FPSF_FLAG_INV] = c[`FPSF_CND_INVALID];
                    f[`FPSF_FLAG_OVF] = c[`FPSF_CND_OVF];
                end else if (c[`FPSF_CND_ZERO]) begin
                    f[`FPSF_FLAG_ZER] = 1'b1;
                    f[`FPSF_FLAG_UNF] = c[`FPSF_CND_TINY];
                    f[`FPSF_FLAG_INE] = c[`FPSF_CND_INEXACT];
                end else if (c[`FPSF_CND_INEXACT]) begin
                    f[`FPSF_FLAG_INE] = 1'b1;
                    f[`FPSF_FLAG_OVF] = c[`FPSF_CND_OVF];
                    f[`FPSF_FLAG_UNF] = c[`FPSF_CND_TINY];
                end
            end
            flags_for = f;
        end
    endfunction

    // ------------------------------------------------------------------
    // Pass-through select synchronisers
    // ------------------------------------------------------------------
    wire [1:0] pt_sync;

    fpsf_sync2 #(
        .WIDTH    (2)
    ) u_pt_sync (
        .clk_in   (CORE_CLK_IN),
        .rst_b_in (RST_B_IN),
        .async_in ({OUTPUT_PASS_THROUGH_SEL_IN, INPUT_PASS_THROUGH_SEL_IN}),
        .sync_out (pt_sync)
    );

    wire in_pt  = pt_sync[0];
    wire out_pt = pt_sync[1];

    // ------------------------------------------------------------------
    // Input stage
    // ------------------------------------------------------------------
    wire [`FPSF_CND_W-1:0] cnd_live = {INT_RANGE_ERR_IN, INPUT_NAN_IN, RESULT_NAN_IN,
                                       RESULT_ZERO_IN, RESULT_INEXACT_IN, RESULT_TINY_IN,
                                       RESULT_OVF_IN, FINITE_OPERANDS_IN, INVALID_CASE_IN};

    reg [`FPSF_CND_W-1:0] cnd_r;
    reg [2:0]             op_r;
    reg                   mode_r;

    // Held contents are used only when the input stage is not transparent
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            cnd_r  <= `FPSF_CND_RST;
            op_r   <= `FPSF_OP_RST;
            mode_r <= `FPSF_MODE_IEEE;
        end else if (INPUT_REG_EN_IN) begin
            cnd_r  <= cnd_live;
            op_r   <= OP_SEL_IN;
            mode_r <= IEEE_MODE_IN;
        end
    end

    // Clocked mode is kept for completeness but is not the qualified use
    wire [`FPSF_CND_W-1:0] cnd_use  = in_pt ? cnd_live : cnd_r;
    wire [2:0]             op_use   = in_pt ? OP_SEL_IN : op_r;
    wire                   mode_use = in_pt ? IEEE_MODE_IN : mode_r;

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    wire [`FPSF_FLAG_W-1:0] flags_nxt = flags_for(op_use, mode_use, cnd_use);
    reg  [`FPSF_FLAG_W-1:0] flags_r;

    // Flags stay registered even when transparent, so they settle one clock late
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            flags_r <= `FPSF_FLAGS_RST;
        end else if (out_pt || OUTPUT_REG_EN_IN) begin
            flags_r <= flags_nxt;
        end
    end

    assign INVALID_OP_FLAG_OUT        = flags_r[`FPSF_FLAG_INV];
    assign RESULT_TOO_LARGE_FLAG_OUT  = flags_r[`FPSF_FLAG_OVF];
    assign RESULT_TOO_SMALL_FLAG_OUT  = flags_r[`FPSF_FLAG_UNF];
    assign ROUNDING_OCCURRED_FLAG_OUT = flags_r[`FPSF_FLAG_INE];
    assign ZERO_RESULT_FLAG_OUT       = flags_r[`FPSF_FLAG_ZER];
    assign NAN_FLAG_OUT               = flags_r[`FPSF_FLAG_NAN];

endmodule // fpsf_flag_logic

// ===== hdl/fpsf_defines.vh
// Constants shared by the floating-point status flag logic.
// Assumes opcodes arrive on a 3-bit select and flags leave as a 6-bit vector.
`ifndef FPSF_DEFINES_VH
`define FPSF_DEFINES_VH

// ----------------------------------------------------------------------
// Operation select codes
// ----------------------------------------------------------------------
`define FPSF_OP_R_PLUS_S      3'h0
`define FPSF_OP_R_MINUS_S     3'h1
`define FPSF_OP_R_TIMES_S     3'h2
`define FPSF_OP_TWO_MINUS_S   3'h3
`define FPSF_OP_INT_TO_FLOAT  3'h4
`define FPSF_OP_FLOAT_TO_INT  3'h5
`define FPSF_OP_IEEE_TO_ALT   3'h6
`define FPSF_OP_ALT_TO_IEEE   3'h7

// ----------------------------------------------------------------------
// Format mode select
// ----------------------------------------------------------------------
`define FPSF_MODE_ALT         1'h0
`define FPSF_MODE_IEEE        1'h1

// ----------------------------------------------------------------------
// Flag vector bit positions
// ----------------------------------------------------------------------
`define FPSF_FLAG_INV         0
`define FPSF_FLAG_OVF         1
`define FPSF_FLAG_UNF         2
`define FPSF_FLAG_INE         3
`define FPSF_FLAG_ZER         4
`define FPSF_FLAG_NAN         5
`define FPSF_FLAG_W           6

// ----------------------------------------------------------------------
// Condition vector bit positions (from the arithmetic datapath)
// ----------------------------------------------------------------------
`define FPSF_CND_INVALID      0
`define FPSF_CND_FINITE       1
`define FPSF_CND_OVF          2
`define FPSF_CND_TINY         3
`define FPSF_CND_INEXACT      4
`define FPSF_CND_ZERO         5
`define FPSF_CND_RES_NAN      6
`define FPSF_CND_IN_NAN       7
`define FPSF_CND_INT_RANGE    8
`define FPSF_CND_W            9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FPSF_FLAGS_RST        6'h00
`define FPSF_CND_RST          9'h000
`define FPSF_OP_RST           3'h0
`define FPSF_SYNC_RST         1'h1

`endif

// ===== hdl/fpsf_sync2.v
// Two-flop synchroniser for a group of level inputs.
// Assumes each bit is a slow level; no relation between bits is kept.
`timescale 1ns/1ps
`include "fpsf_defines.vh"

module fpsf_sync2 #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_b_in,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            // Per-bit flops, so each variable has a single process driving it
            reg meta_r;
            reg hold_r;

            // Resets high so the unit starts in pass-through
            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    meta_r <= `FPSF_SYNC_RST;
                    hold_r <= `FPSF_SYNC_RST;
                end else begin
                    meta_r <= async_in[g];
                    hold_r <= meta_r;
                end
            end

            assign sync_out[g] = hold_r;
        end
    endgenerate

endmodule // fpsf_sync2

// ===== bench/fpsf_flag_chk.sv
// Checker for the flag logic; sees only the top module's ports.
// Assumes both selects stay high, so flags follow the inputs one clock late.
`timescale 1ns/1ps

module fpsf_flag_chk (
    // Clock and reset
    input wire       CORE_CLK_IN, RST_B_IN,
    // Operation and conditions
    input wire [2:0] OP_SEL_IN,
    input wire       IEEE_MODE_IN, INVALID_CASE_IN, FINITE_OPERANDS_IN, RESULT_OVF_IN,
    input wire       RESULT_TINY_IN, RESULT_INEXACT_IN, RESULT_ZERO_IN, RESULT_NAN_IN,
    input wire       INPUT_NAN_IN, INT_RANGE_ERR_IN,
    input wire       INPUT_PASS_THROUGH_SEL_IN, OUTPUT_PASS_THROUGH_SEL_IN,
    // Flags
    input wire       INVALID_OP_FLAG_OUT, RESULT_TOO_LARGE_FLAG_OUT, RESULT_TOO_SMALL_FLAG_OUT,
    input wire       ROUNDING_OCCURRED_FLAG_OUT, ZERO_RESULT_FLAG_OUT, NAN_FLAG_OUT
);
    reg  [1:0] pt_r;
    wire [5:0] f   = {NAN_FLAG_OUT, ZERO_RESULT_FLAG_OUT, ROUNDING_OCCURRED_FLAG_OUT,
                      RESULT_TOO_SMALL_FLAG_OUT, RESULT_TOO_LARGE_FLAG_OUT, INVALID_OP_FLAG_OUT};
    wire       ok  = pt_r == 2'h3;
    wire       ie  = ok && IEEE_MODE_IN && OP_SEL_IN < 3'h6;
    wire       al  = ok && !IEEE_MODE_IN && OP_SEL_IN < 3'h6;
    wire       ar  = OP_SEL_IN < 3'h4;
    wire       mu  = OP_SEL_IN < 3'h3;
    wire       f5  = OP_SEL_IN == 3'h5;
    wire       big = RESULT_OVF_IN || RESULT_TINY_IN;

    // Selects pass a synchroniser, so judge only once they have settled
    always @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN)
            pt_r <= 2'h0;
        else if (!(INPUT_PASS_THROUGH_SEL_IN && OUTPUT_PASS_THROUGH_SEL_IN))
            pt_r <= 2'h0;
        else if (pt_r != 2'h3)
            pt_r <= pt_r + 2'h1;
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    AST_IEEE_INVALID: assert property (ie && INVALID_CASE_IN |=> f == 6'h21)
        else $error("invalid case flags wrong");
    AST_IEEE_OVF: assert property (ie && ar && !INVALID_CASE_IN && FINITE_OPERANDS_IN
        && RESULT_OVF_IN |=> f == 6'h0a) else $error("ieee overflow flags wrong");
    AST_TINY: assert property (((ie && mu && !INVALID_CASE_IN && !RESULT_OVF_IN)
        || (ok && OP_SEL_IN == 3'h7 && !INPUT_NAN_IN)) && RESULT_TINY_IN |=> f == 6'h1c)
        else $error("tiny result flags wrong");
    AST_INEXACT: assert property (ok && OP_SEL_IN < 3'h6 && !INVALID_CASE_IN && !INPUT_NAN_IN
        && !INT_RANGE_ERR_IN && !big && !RESULT_NAN_IN && !RESULT_ZERO_IN && RESULT_INEXACT_IN
        |=> f == 6'h08) else $error("inexact flags wrong");
    AST_ZERO: assert property (ie && !INVALID_CASE_IN && !big && !RESULT_NAN_IN && RESULT_ZERO_IN
        |=> f[4] && f[2:0] == 3'h0 && !f[5] && f[3] == $past(RESULT_INEXACT_IN))
        else $error("zero result flags wrong");
    AST_IEEE_NAN: assert property (ie && (ar || f5) && !INVALID_CASE_IN && !big && RESULT_NAN_IN
        |=> f == 6'h20) else $error("nan result flags wrong");
    AST_ALT_RANGE: assert property (al && f5 && !INPUT_NAN_IN && INT_RANGE_ERR_IN
        |=> f == 6'h21) else $error("integer range flags wrong");
    AST_RSV_INPUT: assert property (ok && INPUT_NAN_IN && (OP_SEL_IN == 3'h7 || al && f5)
        |=> f == 6'h21) else $error("reserved input flags wrong");
    AST_ALT_OVF: assert property (al && ar && RESULT_OVF_IN |=> f == 6'h2a)
        else $error("alternate overflow flags wrong");
    AST_ALT_TINY: assert property (al && mu && !RESULT_OVF_IN && RESULT_TINY_IN |=> f == 6'h1c)
        else $error("alternate tiny flags wrong");
    AST_ALT_RSV: assert property (al && (ar || f5) && !INPUT_NAN_IN && !INT_RANGE_ERR_IN && !big
        && RESULT_NAN_IN |=> f[5] && f[4:2] == 3'h0 && f[0] == $past(INVALID_CASE_IN))
        else $error("reserved result flags wrong");
endmodule // fpsf_flag_chk

bind fpsf_flag_logic fpsf_flag_chk u_chk (
    .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .OP_SEL_IN(OP_SEL_IN),
    .IEEE_MODE_IN(IEEE_MODE_IN), .INVALID_CASE_IN(INVALID_CASE_IN),
    .FINITE_OPERANDS_IN(FINITE_OPERANDS_IN), .RESULT_OVF_IN(RESULT_OVF_IN),
    .RESULT_TINY_IN(RESULT_TINY_IN), .RESULT_INEXACT_IN(RESULT_INEXACT_IN),
    .RESULT_ZERO_IN(RESULT_ZERO_IN), .RESULT_NAN_IN(RESULT_NAN_IN),
    .INPUT_NAN_IN(INPUT_NAN_IN), .INT_RANGE_ERR_IN(INT_RANGE_ERR_IN),
    .INPUT_PASS_THROUGH_SEL_IN(INPUT_PASS_THROUGH_SEL_IN),
    .OUTPUT_PASS_THROUGH_SEL_IN(OUTPUT_PASS_THROUGH_SEL_IN),
    .INVALID_OP_FLAG_OUT(INVALID_OP_FLAG_OUT), .NAN_FLAG_OUT(NAN_FLAG_OUT),
    .RESULT_TOO_LARGE_FLAG_OUT(RESULT_TOO_LARGE_FLAG_OUT),
    .RESULT_TOO_SMALL_FLAG_OUT(RESULT_TOO_SMALL_FLAG_OUT),
    .ROUNDING_OCCURRED_FLAG_OUT(ROUNDING_OCCURRED_FLAG_OUT),
    .ZERO_RESULT_FLAG_OUT(ZERO_RESULT_FLAG_OUT)
);

// ===== bench/fpsf_host_model.sv
// Host model: controller and datapath that feed the flag logic.
// Assumes the bench asks for at most one condition set per falling edge.
`timescale 1ns/1ps

module fpsf_host_model (
    // Clock
    input  wire       clk_in,
    // Operation and conditions
    output reg  [2:0] op_out,
    output reg        ieee_out,
    output reg  [8:0] cnd_out,
    // Selects and enables
    output wire [3:0] ctl_out
);
    // Clocked mode is not guaranteed, so both selects stay high
    assign ctl_out = 4'hf;

    initial begin
        op_out   = 3'h0;
        ieee_out = 1'b1;
        cnd_out  = 9'h000;
    end

    task apply(input [2:0] op, input ieee, input [8:0] cnd);
        begin
            @(negedge clk_in);
            op_out   = op;
            ieee_out = ieee;
            cnd_out  = cnd;
        end
    endtask
endmodule // fpsf_host_model

// ===== bench/tb_top.sv
// Self-checking bench for the flag logic, one task per scenario.
// Assumes one clock of flag latency with both selects high.
`timescale 1ns/1ps

module tb_top;
    localparam [8:0] c_inv = 9'h001, c_fin = 9'h002, c_ovf = 9'h004, c_tny = 9'h008;
    localparam [8:0] c_ine = 9'h010, c_zer = 9'h020, c_nan = 9'h040, c_rsv = 9'h080;
    localparam [8:0] c_rng = 9'h100;
    reg        core_clk;
    reg        rst_b;
    reg        pend;
    reg  [5:0] pexp;
    integer    miscompares;
    integer    checked;
    wire [2:0] op;
    wire       ieee;
    wire [8:0] cnd;
    wire [3:0] ctl;
    wire [5:0] flags;

    fpsf_flag_logic dut (
        .CORE_CLK_IN(core_clk), .RST_B_IN(rst_b), .OP_SEL_IN(op), .IEEE_MODE_IN(ieee),
        .INVALID_CASE_IN(cnd[0]), .FINITE_OPERANDS_IN(cnd[1]), .RESULT_OVF_IN(cnd[2]),
        .RESULT_TINY_IN(cnd[3]), .RESULT_INEXACT_IN(cnd[4]), .RESULT_ZERO_IN(cnd[5]),
        .RESULT_NAN_IN(cnd[6]), .INPUT_NAN_IN(cnd[7]), .INT_RANGE_ERR_IN(cnd[8]),
        .INPUT_PASS_THROUGH_SEL_IN(ctl[3]), .OUTPUT_PASS_THROUGH_SEL_IN(ctl[2]),
        .INPUT_REG_EN_IN(ctl[1]), .OUTPUT_REG_EN_IN(ctl[0]),
        .INVALID_OP_FLAG_OUT(flags[0]), .RESULT_TOO_LARGE_FLAG_OUT(flags[1]),
        .RESULT_TOO_SMALL_FLAG_OUT(flags[2]), .ROUNDING_OCCURRED_FLAG_OUT(flags[3]),
        .ZERO_RESULT_FLAG_OUT(flags[4]), .NAN_FLAG_OUT(flags[5]));
    fpsf_host_model host (.clk_in(core_clk), .op_out(op), .ieee_out(ieee), .cnd_out(cnd),
        .ctl_out(ctl));

    task chk(input [5:0] seen, input [5:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD at %0t: flags %h, want %h", $time, seen, exp);
            end
        end
    endtask

    // Ops go back to back: each call presents its own, then judges the previous one
    task step(input [2:0] o, input m, input [8:0] c, input [5:0] exp);
        begin
            host.apply(o, m, c);
            if (pend) chk(flags, pexp);
            pexp = exp;
            pend = 1'b1;
        end
    endtask

    task drain;
        begin
            @(negedge core_clk);
            if (pend) chk(flags, pexp);
            pend = 1'b0;
        end
    endtask

    task t_ieee;
        integer o;
        begin
            for (o = 0; o < 6; o = o + 1) begin
                step(o[2:0], 1'b1, c_inv | c_fin | c_ovf | c_nan, 6'h21);
                if (o < 4) step(o[2:0], 1'b1, c_fin | c_ovf | c_ine, 6'h0a);
                if (o < 3) step(o[2:0], 1'b1, c_tny | c_ine | c_zer, 6'h1c);
                if (o != 4) step(o[2:0], 1'b1, c_nan, 6'h20);
            end
            step(3'h0, 1'b1, c_ovf | c_ine, 6'h0a);
            drain;
        end
    endtask

    task t_alt;
        integer o;
        begin
            step(3'h5, 1'b0, c_rsv | c_rng, 6'h21);
            step(3'h5, 1'b0, c_rng | c_ine, 6'h21);
            step(3'h5, 1'b0, c_nan | c_ovf, 6'h22);
            for (o = 0; o < 4; o = o + 1) begin
                step(o[2:0], 1'b0, c_ovf | c_ine | c_nan, 6'h2a);
                if (o < 3) step(o[2:0], 1'b0, c_tny | c_ine | c_zer, 6'h1c);
                step(o[2:0], 1'b0, c_nan | c_inv, 6'h21);
            end
            drain;
        end
    endtask

    task t_conv;
        integer m;
        begin
            for (m = 0; m < 2; m = m + 1) begin
                step(3'h7, m[0], c_rsv | c_tny, 6'h21);
                step(3'h7, m[0], c_tny | c_ine | c_zer, 6'h1c);
                step(3'h6, m[0], c_zer | c_tny | c_ine, 6'h1c);
                step(3'h7, m[0], c_zer, 6'h10);
            end
            drain;
        end
    endtask

    task t_common;
        integer k;
        begin
            for (k = 0; k < 12; k = k + 1) begin
                step(k[2:0] % 3'h6, k[3] | k[2] & k[1], c_ine, 6'h08);
                step(k[2:0] % 3'h6, k[3] | k[2] & k[1], c_zer, 6'h10);
            end
            drain;
        end
    endtask

    // Reset in mid-run must clear the flags without waiting for a clock
    task t_reset;
        begin
            step(3'h0, 1'b1, c_fin | c_ovf | c_ine, 6'h0a);
            drain;
            @(negedge core_clk) rst_b = 1'b0;
            #1 chk(flags, 6'h00);
            @(negedge core_clk) rst_b = 1'b1;
            step(3'h1, 1'b1, c_zer, 6'h10);
            drain;
        end
    endtask

    task stop_test;
        begin
            $display("Comparisons %0d, mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        miscompares = 0;
        checked = 0;
        pend = 1'b0;
        pexp = 6'h00;
        rst_b = 1'b0;
        repeat (12) @(negedge core_clk);
        chk(flags, 6'h00);
        rst_b = 1'b1;
        t_ieee;
        t_alt;
        t_conv;
        t_common;
        t_reset;
        stop_test;
    end

    initial begin
        repeat (2000) @(posedge core_clk);
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule // tb_top
